/* File: tst_defs.vh */
// Purpose: Constants for the touch secondary threshold block.
// Assumes: Register indices are word indices; byte address is index * 4.
// Notes:   Included by tst_scale.v and tst_thresholds.v.
`ifndef TST_DEFS_VH
`define TST_DEFS_VH

// Register word indices
`define TST_IDX_NOISE1 8'h38
`define TST_IDX_NOISE2 8'h39
`define TST_IDX_LID1 8'h3A
`define TST_IDX_LID2 8'h3B
`define TST_IDX_LID3 8'h3C
`define TST_IDX_LID4 8'h3D
`define TST_IDX_LIDSTAT 8'h40
`define TST_IDX_TOUCHSTAT 8'h41

// Reset values
`define TST_RST_NOISE 8'h55
`define TST_RST_LID 8'hAA
`define TST_RST_LID4 8'h0A

// Field layout
`define TST_CODE_W 2
`define TST_LID4_MASK 8'h0F
`define TST_GRP_NOISE_POS 14
`define TST_NUM_SENS 4'hE
`define TST_GRP_FIRST 4'h7
`define TST_NUM_SENS_W 14

// Ratio code to right shift: shift = base - code
`define TST_SHIFT_BASE 3'h4

// AXI responses
`define TST_RESP_OKAY 2'h0
`define TST_RESP_SLVERR 2'h2

`endif

/* File: tst_scale.v */
// Purpose: Scale a touch threshold by a ratio code and compare a delta.
// Assumes: Code 0..3 selects 6.25, 12.5, 25 or 50 percent.
// Notes:   Purely combinational; truncates the scaled value.
`timescale 1ns/100ps
`include "tst_defs.vh"

module tst_scale #(
   parameter THR_W = 7,
   parameter DELTA_W = 8
) (
   input wire [THR_W-1:0] thr,
   input wire [`TST_CODE_W-1:0] code,
   input wire [DELTA_W-1:0] delta,
   output wire [THR_W-1:0] scaled,
   output wire above
);

   // Shift of 4, 3, 2 or 1 for codes 0..3
   wire [2:0] shift;
   // Zero extended scaled level, so the compare never drops bits
   wire [DELTA_W:0] scaled_ext;

   assign shift = `TST_SHIFT_BASE - {1'b0, code};
   assign scaled = thr >> shift;
   assign scaled_ext = {{(DELTA_W + 1 - THR_W){1'b0}}, scaled};
   // Strictly greater: a delta equal to the level is not above it
   assign above = {1'b0, delta} > scaled_ext;

endmodule

/* File: tst_thresholds.v */
// Purpose: Secondary noise and lid thresholds for a touch controller.
// Assumes: AXI4-Lite register access; samples arrive on aclk.
// Notes:   Touch thresholds come in as ports; averaging lives elsewhere.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "tst_defs.vh"

module tst_thresholds #(
   parameter ADDR_W = 12,
   parameter THR_W = 7,
   parameter DELTA_W = 8
) (
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite write address
   input wire [ADDR_W-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // AXI4-Lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [ADDR_W-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // AXI4-Lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Touch thresholds: sensors 1..7 then the group, THR_W bits each
   input wire [8*THR_W-1:0] touch_thr,
   // One measured sample
   input wire sample_valid,
   input wire [3:0] sample_sensor,
   input wire [DELTA_W-1:0] sample_delta,
   // Per sample results: one-cycle pulses, and the sensor index registered every cycle
   output reg result_valid_r,
   output reg [3:0] result_sensor_r,
   output reg result_touch_r,
   output reg result_noise_r,
   output reg result_recal_ok_r,
   // Per sensor status levels
   output reg [`TST_NUM_SENS_W-1:0] touch_status_r,
   output reg [`TST_NUM_SENS_W-1:0] lid_status_r
);

   // Register selectors, one-hot
   localparam [7:0] SEL_NONE = 8'h00;
   localparam [7:0] SEL_NOISE1 = 8'h01;
   localparam [7:0] SEL_NOISE2 = 8'h02;
   localparam [7:0] SEL_LID1 = 8'h04;
   localparam [7:0] SEL_LID2 = 8'h08;
   localparam [7:0] SEL_LID3 = 8'h10;
   localparam [7:0] SEL_LID4 = 8'h20;
   localparam [7:0] SEL_LIDSTAT = 8'h40;
   localparam [7:0] SEL_TOUCHSTAT = 8'h80;

   // Ratio registers
   reg [7:0] noise1_r; // Sensors 4..1 noise codes
   reg [7:0] noise2_r; // Group code and sensors 7..5
   reg [7:0] lid1_r; // Sensors 4..1 lid codes
   reg [7:0] lid2_r; // Sensors 8..5 lid codes
   reg [7:0] lid3_r; // Sensors 12..9 lid codes
   reg [7:0] lid4_r; // Sensors 14..13, upper nibble unused

   // Write channel holding state
   reg aw_held_r; // Address taken, waiting for data or commit
   reg w_held_r; // Data taken, waiting for address or commit
   reg [ADDR_W-1:0] awaddr_r; // Captured write address
   reg [31:0] wdata_r; // Captured write data
   reg [3:0] wstrb_r; // Captured byte strobes

   // Address to selector; shared by read and write paths
   function [7:0] sel_of;
      input [ADDR_W-1:0] a;
      begin
         sel_of = SEL_NONE;
         // Anything above the decoded window is unmapped
         if (a[ADDR_W-1:10] == {(ADDR_W-10){1'b0}}) begin
            case (a[9:2])
               `TST_IDX_NOISE1: sel_of = SEL_NOISE1;
               `TST_IDX_NOISE2: sel_of = SEL_NOISE2;
               `TST_IDX_LID1: sel_of = SEL_LID1;
               `TST_IDX_LID2: sel_of = SEL_LID2;
               `TST_IDX_LID3: sel_of = SEL_LID3;
               `TST_IDX_LID4: sel_of = SEL_LID4;
               `TST_IDX_LIDSTAT: sel_of = SEL_LIDSTAT;
               `TST_IDX_TOUCHSTAT: sel_of = SEL_TOUCHSTAT;
               default: sel_of = SEL_NONE;
            endcase
         end
      end
   endfunction

   // Handshakes on the request channels
   wire aw_hs;
   wire w_hs;
   wire ar_hs;
   // Commit happens once both halves are held and no response is pending
   wire do_write;
   wire [7:0] wsel;
   wire [7:0] rsel;
   wire wr_lo; // Low byte lane enabled
   wire wr_hi; // Second byte lane enabled

   assign aw_hs = s_axi_awvalid & s_axi_awready;
   assign w_hs = s_axi_wvalid & s_axi_wready;
   assign ar_hs = s_axi_arvalid & s_axi_arready;
   assign do_write = aw_held_r & w_held_r & ~s_axi_bvalid;
   assign wsel = sel_of(awaddr_r);
   assign rsel = sel_of(s_axi_araddr);
   assign wr_lo = do_write & wstrb_r[0];
   assign wr_hi = do_write & wstrb_r[1];

   // Flattened code vectors, two bits per sensor
   wire [15:0] noise_codes;
   wire [27:0] lid_codes;
   assign noise_codes = {noise2_r, noise1_r};
   assign lid_codes = {lid4_r[3:0], lid3_r,
                       lid2_r, lid1_r};

   // Sample decode
   wire samp_ok; // Sensor index in range
   wire samp_grp; // Sensor belongs to the group
   reg [THR_W-1:0] samp_thr;
   reg [1:0] samp_ncode;
   reg [1:0] samp_lcode;
   wire samp_touch;
   wire noise_above;
   wire lid_above;

   assign samp_ok = sample_valid & (sample_sensor < `TST_NUM_SENS);
   assign samp_grp = sample_sensor >= `TST_GRP_FIRST;

   // Pick threshold and codes for the sampled sensor
   always @* begin
      if (samp_grp) begin
         // Grouped sensors share one threshold and one noise code
         samp_thr = touch_thr[7*THR_W +: THR_W];
         samp_ncode = noise_codes[`TST_GRP_NOISE_POS +: 2];
      end else begin
         samp_thr = touch_thr[sample_sensor[2:0]*THR_W +: THR_W];
         samp_ncode = noise_codes[{sample_sensor[2:0], 1'b0} +: 2];
      end
      // Out of range index reads sensor 1; result is dropped anyway
      if (samp_ok) begin
         samp_lcode = lid_codes[{sample_sensor, 1'b0} +: 2];
      end else begin
         samp_lcode = lid_codes[1:0];
      end
   end

   // Touch decision against the full threshold
   assign samp_touch = {1'b0, sample_delta} >
                       {{(DELTA_W + 1 - THR_W){1'b0}}, samp_thr};

   // Noise level comparator
   tst_scale #(
      .THR_W(THR_W),
      .DELTA_W(DELTA_W)
   ) u_noise (
      .thr(samp_thr),
      .code(samp_ncode),
      .delta(sample_delta),
      .scaled(),
      .above(noise_above)
   );

   // Lid level comparator
   tst_scale #(
      .THR_W(THR_W),
      .DELTA_W(DELTA_W)
   ) u_lid (
      .thr(samp_thr),
      .code(samp_lcode),
      .delta(sample_delta),
      .scaled(),
      .above(lid_above)
   );

   // Lid status next value: hardware set beats software clear
   wire [`TST_NUM_SENS_W-1:0] lid_set;
   wire [`TST_NUM_SENS_W-1:0] lid_clr;
   wire [`TST_NUM_SENS_W-1:0] lid_status_nxt;
   wire [`TST_NUM_SENS_W-1:0] touch_status_nxt;
   wire [`TST_NUM_SENS_W-1:0] samp_onehot;
   wire lidstat_wr;

   genvar gi;
   generate
      for (gi = 0; gi < `TST_NUM_SENS_W; gi = gi + 1) begin : g_sens
         assign samp_onehot[gi] = samp_ok & (sample_sensor == gi);
         assign lid_set[gi] = samp_onehot[gi] & lid_above;
         // Low byte lane clears sensors 1..8, next lane 9..14
         if (gi < 8) begin : g_lo
            assign lid_clr[gi] = lidstat_wr & wr_lo & wdata_r[gi];
         end else begin : g_hi
            assign lid_clr[gi] = lidstat_wr & wr_hi & wdata_r[gi];
         end
         // Touch status follows the latest sample of each sensor
         assign touch_status_nxt[gi] = samp_onehot[gi] ? samp_touch :
                                       touch_status_r[gi];
      end
   endgenerate

   assign lidstat_wr = (wsel == SEL_LIDSTAT);
   assign lid_status_nxt = (lid_status_r & ~lid_clr) | lid_set;

   // Per sample result pulses
   always @(posedge aclk) begin
      if (!aresetn) begin
         result_valid_r <= 1'b0;
         result_sensor_r <= 4'h0;
         result_touch_r <= 1'b0;
         result_noise_r <= 1'b0;
         result_recal_ok_r <= 1'b0;
         touch_status_r <= {`TST_NUM_SENS_W{1'b0}};
         lid_status_r <= {`TST_NUM_SENS_W{1'b0}};
      end else begin
         result_valid_r <= samp_ok;
         result_sensor_r <= sample_sensor;
         result_touch_r <= samp_ok & samp_touch;
         // Noise band: above noise level, at or below touch threshold
         result_noise_r <= samp_ok & noise_above & ~samp_touch;
         // Noise spikes never feed the averaging
         result_recal_ok_r <= samp_ok & ~(noise_above & ~samp_touch);
         touch_status_r <= touch_status_nxt;
         lid_status_r <= lid_status_nxt;
      end
   end

   // Ratio registers; a write needs the low byte lane
   always @(posedge aclk) begin
      if (!aresetn) begin
         noise1_r <= `TST_RST_NOISE;
         noise2_r <= `TST_RST_NOISE;
         lid1_r <= `TST_RST_LID;
         lid2_r <= `TST_RST_LID;
         lid3_r <= `TST_RST_LID;
         lid4_r <= `TST_RST_LID4;
      end else if (wr_lo) begin
         case (wsel)
            SEL_NOISE1: noise1_r <= wdata_r[7:0];
            SEL_NOISE2: noise2_r <= wdata_r[7:0];
            SEL_LID1: lid1_r <= wdata_r[7:0];
            SEL_LID2: lid2_r <= wdata_r[7:0];
            SEL_LID3: lid3_r <= wdata_r[7:0];
            // Unused upper nibble stays zero
            SEL_LID4: lid4_r <= wdata_r[7:0] & `TST_LID4_MASK;
            default: lid4_r <= lid4_r;
         endcase
      end
   end

   // Write channels: take address and data in either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awaddr_r <= {ADDR_W{1'b0}};
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `TST_RESP_OKAY;
      end else begin
         // Address half
         if (aw_hs) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else if (do_write) begin
            aw_held_r <= 1'b0;
            s_axi_awready <= 1'b1;
         end
         // Data half
         if (w_hs) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end else if (do_write) begin
            w_held_r <= 1'b0;
            s_axi_wready <= 1'b1;
         end
         // Response one cycle after commit
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            // Read-only and unmapped words answer with an error
            if ((wsel == SEL_NONE) || (wsel == SEL_TOUCHSTAT)) begin
               s_axi_bresp <= `TST_RESP_SLVERR;
            end else begin
               s_axi_bresp <= `TST_RESP_OKAY;
            end
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read data for the selected word; unused bits read zero
   reg [31:0] rd_word;
   always @* begin
      rd_word = 32'h00000000;
      case (rsel)
         SEL_NOISE1: rd_word[7:0] = noise1_r;
         SEL_NOISE2: rd_word[7:0] = noise2_r;
         SEL_LID1: rd_word[7:0] = lid1_r;
         SEL_LID2: rd_word[7:0] = lid2_r;
         SEL_LID3: rd_word[7:0] = lid3_r;
         SEL_LID4: rd_word[7:0] = lid4_r;
         SEL_LIDSTAT: rd_word[13:0] = lid_status_r;
         SEL_TOUCHSTAT: rd_word[13:0] = touch_status_r;
         default: rd_word = 32'h00000000;
      endcase
   end

   // Read channel: one outstanding read, answered next cycle
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `TST_RESP_OKAY;
      end else begin
         if (ar_hs) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            if (rsel == SEL_NONE) begin
               s_axi_rresp <= `TST_RESP_SLVERR;
            end else begin
               s_axi_rresp <= `TST_RESP_OKAY;
            end
         end else if (s_axi_rvalid & s_axi_rready) begin
            // Accept a new read only after this one is gone
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule

/* File: tst_thresholds_assertions.sv */
// Purpose: Concurrent checks on the sample path of tst_thresholds.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Watches design ports only, inputs and outputs; bound below.
`timescale 1ns/100ps
module tst_thresholds_assertions #(
   parameter THR_W = 7,
   parameter DELTA_W = 8
) (
   input wire aclk,
   input wire aresetn,
   input wire [8*THR_W-1:0] touch_thr,
   input wire sample_valid,
   input wire [3:0] sample_sensor,
   input wire [DELTA_W-1:0] sample_delta,
   input wire result_valid_r,
   input wire [3:0] result_sensor_r,
   input wire result_touch_r,
   input wire result_noise_r,
   input wire result_recal_ok_r,
   input wire [13:0] touch_status_r,
   input wire [13:0] lid_status_r
);
   // Threshold of the sampled sensor; grouped sensors share the last one
   wire [THR_W-1:0] cur_thr = (sample_sensor < 4'h7) ?
      touch_thr[sample_sensor*THR_W +: THR_W] : touch_thr[7*THR_W +: THR_W];
   // Widen for compares
   wire [DELTA_W-1:0] thr_ext = {{(DELTA_W - THR_W){1'b0}}, cur_thr};
   // Accepted sample: in range only
   wire take = sample_valid && (sample_sensor < 4'hE);
   // Any code gives a level at or below half the threshold
   wire band = (sample_delta > (thr_ext >> 1)) && (sample_delta <= thr_ext);
   // Below the smallest level no code can flag noise
   wire floor = sample_delta <= (thr_ext >> 4);

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // A sample the block must judge
   sequence s_take;
      take;
   endsequence

   a_valid_pulse: assert property (s_take |=> result_valid_r)
      else $error("result valid missing");
   a_valid_drop: assert property (!take |=> !result_valid_r)
      else $error("result valid without sample");
   a_touch_level: assert property (s_take |=>
      result_touch_r == ($past(sample_delta) > $past(thr_ext)))
      else $error("touch decision wrong");
   a_noise_band: assert property (take && band |=>
      result_noise_r && !result_recal_ok_r)
      else $error("noise spike not excluded");
   a_noise_floor: assert property (take && floor |=>
      !result_noise_r && result_recal_ok_r)
      else $error("noise flagged below lowest level");
   a_noise_exclusive: assert property (result_noise_r |->
      result_valid_r && !result_touch_r && !result_recal_ok_r)
      else $error("noise flag inconsistent");
   a_touch_status: assert property (result_valid_r |->
      touch_status_r[result_sensor_r] == result_touch_r)
      else $error("touch status differs from result");
   a_lid_on_touch: assert property (result_touch_r |->
      lid_status_r[result_sensor_r])
      else $error("lid status not set by touch");
endmodule

bind tst_thresholds tst_thresholds_assertions #(
   .THR_W(THR_W),
   .DELTA_W(DELTA_W)
) chk_u (
   .aclk(aclk),
   .aresetn(aresetn),
   .touch_thr(touch_thr),
   .sample_valid(sample_valid),
   .sample_sensor(sample_sensor),
   .sample_delta(sample_delta),
   .result_valid_r(result_valid_r),
   .result_sensor_r(result_sensor_r),
   .result_touch_r(result_touch_r),
   .result_noise_r(result_noise_r),
   .result_recal_ok_r(result_recal_ok_r),
   .touch_status_r(touch_status_r),
   .lid_status_r(lid_status_r)
);

/* File: tst_thresholds_tb_top.sv */
// Purpose: Self-checking bench for tst_thresholds.
// Assumes: Registers at byte address index*4 over AXI4-Lite.
// Notes:   Expectations come from a small register model below.
`timescale 1ns/100ps
module tst_thresholds_tb_top;
   reg aclk = 1'b0;
   reg aresetn = 1'b0; // Held low for six cycles
   reg [11:0] s_axi_awaddr = 12'h000;
   reg s_axi_awvalid = 1'b0;
   reg [31:0] s_axi_wdata = 32'h00000000;
   reg [3:0] s_axi_wstrb = 4'h0;
   reg s_axi_wvalid = 1'b0;
   reg s_axi_bready = 1'b0;
   reg [11:0] s_axi_araddr = 12'h000;
   reg s_axi_arvalid = 1'b0;
   reg s_axi_rready = 1'b0;
   reg [55:0] touch_thr = 56'h0;
   reg sample_valid = 1'b0;
   reg [3:0] sample_sensor = 4'h0;
   reg [7:0] sample_delta = 8'h00;
   wire s_axi_awready;
   wire s_axi_wready;
   wire [1:0] s_axi_bresp;
   wire s_axi_bvalid;
   wire s_axi_arready;
   wire [31:0] s_axi_rdata;
   wire [1:0] s_axi_rresp;
   wire s_axi_rvalid;
   wire result_valid_r;
   wire [3:0] result_sensor_r;
   wire result_touch_r;
   wire result_noise_r;
   wire result_recal_ok_r;
   wire [13:0] touch_status_r;
   wire [13:0] lid_status_r;
   integer fails = 0;
   integer n_compared = 0;
   integer seed = 94;
   integer cyc = 0;
   integer i;
   integer k;
   integer s;
   reg [7:0] m [0:5]; // Model of the six ratio registers
   reg [13:0] exp_lid = 14'h0;
   reg [13:0] exp_ts = 14'h0;
   reg [31:0] rd_d;
   reg [1:0] rsp;
   reg [6:0] t;
   reg [63:0] r64; // Raw draw for the threshold vector
   reg [31:0] rv; // Raw draw, sliced on purpose

   tst_thresholds dut_u (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .touch_thr(touch_thr),
      .sample_valid(sample_valid),
      .sample_sensor(sample_sensor),
      .sample_delta(sample_delta),
      .result_valid_r(result_valid_r),
      .result_sensor_r(result_sensor_r),
      .result_touch_r(result_touch_r),
      .result_noise_r(result_noise_r),
      .result_recal_ok_r(result_recal_ok_r),
      .touch_status_r(touch_status_r),
      .lid_status_r(lid_status_r)
   );

   // 20 MHz clock
   initial begin
      forever #25 aclk = ~aclk;
   end

   // Run limit; a hang counts as a failure
   always @(posedge aclk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         fails = fails + 1;
         close_out;
      end
   end

   task chk(input string what, input [31:0] seen, input [31:0] exp);
      begin
         n_compared = n_compared + 1;
         if (seen !== exp) begin
            fails = fails + 1;
            $display("mismatch %0s expected %0h seen %0h", what, exp, seen);
         end
      end
   endtask

   // Write: offer address and data together, hold until each is taken
   task wr(input [7:0] idx, input [31:0] d, input [3:0] st);
      begin
         s_axi_awaddr <= {2'b00, idx, 2'b00};
         s_axi_wdata <= d;
         s_axi_wstrb <= st;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         @(posedge aclk);
         while (s_axi_bready) begin
            if (s_axi_awready)
               s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
               s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
               rsp = s_axi_bresp;
               s_axi_bready <= 1'b0;
            end
            @(posedge aclk);
         end
      end
   endtask

   task rd(input [7:0] idx);
      begin
         s_axi_araddr <= {2'b00, idx, 2'b00};
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         @(posedge aclk);
         while (s_axi_rready) begin
            if (s_axi_arready)
               s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
               rd_d = s_axi_rdata;
               rsp = s_axi_rresp;
               s_axi_rready <= 1'b0;
            end
            @(posedge aclk);
         end
      end
   endtask

   // Write a ratio register and track it; upper nibble of 3Dh is unused
   task wm(input integer r, input [7:0] d);
      begin
         wr(8'h38 + r, {24'h0, d}, 4'h1);
         m[r] = (r == 5) ? (d & 8'h0F) : d;
         chk("write resp", rsp, 2'h0);
      end
   endtask

   function [6:0] tsel(input [3:0] x);
      tsel = (x < 4'h7) ? touch_thr[x*7 +: 7] : touch_thr[49 +: 7];
   endfunction

   // Scaled level: right shift by four down to one, truncated
   function [7:0] lvl(input [6:0] th, input [1:0] c);
      lvl = {1'b0, th} >> (3'h4 - c);
   endfunction

   function [1:0] ncode(input [3:0] x);
      ncode = (x < 4'h7) ? m[x / 4][2*(x % 4) +: 2] : m[1][7:6];
   endfunction

   function [1:0] lcode(input [3:0] x);
      lcode = m[2 + x / 4][2*(x % 4) +: 2];
   endfunction

   // One sample, judged one cycle later
   task smp(input [3:0] x, input [7:0] d);
      reg tch;
      reg nz;
      begin
         t = tsel(x);
         tch = d > t;
         nz = !tch && (d > lvl(t, ncode(x)));
         sample_valid <= 1'b1;
         sample_sensor <= x;
         sample_delta <= d;
         @(posedge aclk);
         sample_valid <= 1'b0;
         #1;
         if (x < 4'hE) begin
            exp_ts[x] = tch;
            if (d > lvl(t, lcode(x)))
               exp_lid[x] = 1'b1;
            chk("touch", result_touch_r, tch);
            chk("noise", result_noise_r, nz);
            chk("recal ok", result_recal_ok_r, !nz);
         end
         chk("valid", result_valid_r, x < 4'hE);
         chk("sensor", result_sensor_r, x);
         chk("touch status", touch_status_r, exp_ts);
         chk("lid status", lid_status_r, exp_lid);
         @(posedge aclk);
      end
   endtask

   task close_out;
      begin
         $display("compared %0d mismatches %0d", n_compared, fails);
         if (fails == 0 && n_compared > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask

   initial begin
      r64 = {$random(seed), $random(seed)};
      touch_thr <= r64[55:0];
      m[0] = 8'h55;
      m[1] = 8'h55;
      m[2] = 8'hAA;
      m[3] = 8'hAA;
      m[4] = 8'hAA;
      m[5] = 8'h0A;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (i = 0; i < 6; i = i + 1) begin
         rd(8'h38 + i);
         chk("reset value", rd_d, {24'h0, m[i]});
         chk("read resp", rsp, 2'h0);
      end
      rd(8'h20);
      chk("unmapped resp", rsp, 2'h2);
      $display("test reset values done");
      for (i = 0; i < 6; i = i + 1) begin
         rv = $random(seed);
         wm(i, rv[7:0]);
         rd(8'h38 + i);
         chk("readback", rd_d, {24'h0, m[i]});
      end
      wr(8'h38, 32'h000000FF, 4'h0);
      rd(8'h38);
      chk("no strobe", rd_d, {24'h0, m[0]});
      // Touch status is read-only: refused with an error
      wr(8'h41, 32'h00003FFF, 4'h3);
      chk("read-only resp", rsp, 2'h2);
      rd(8'h41);
      chk("touch status kept", rd_d, 32'h00000000);
      $display("test register access done");
      // Every code, at and just past each level and the threshold
      for (k = 0; k < 4; k = k + 1) begin
         for (i = 0; i < 6; i = i + 1)
            wm(i, {4{k[1:0]}});
         for (s = 0; s < 14; s = s + 1) begin
            wr(8'h40, 32'h00003FFF, 4'h3);
            chk("clear resp", rsp, 2'h0);
            exp_lid = 14'h0;
            t = tsel(s[3:0]);
            smp(s[3:0], lvl(t, k[1:0]));
            smp(s[3:0], lvl(t, k[1:0]) + 8'h01);
            smp(s[3:0], {1'b0, t});
            smp(s[3:0], {1'b0, t} + 8'h01);
         end
      end
      $display("test code corners done");
      // Mixed random codes, thresholds and sensors, including bad indices
      for (i = 0; i < 6; i = i + 1) begin
         rv = $random(seed);
         wm(i, rv[7:0]);
      end
      for (i = 0; i < 400; i = i + 1) begin
         if (i % 50 == 0) begin
            r64 = {$random(seed), $random(seed)};
            touch_thr <= r64[55:0];
            @(posedge aclk);
         end
         rv = $random(seed);
         smp(rv[3:0], rv[11:4]);
      end
      // Status words seen over the bus match the sample history
      rd(8'h40);
      chk("lid status read", rd_d, {18'h0, exp_lid});
      rd(8'h41);
      chk("touch status read", rd_d, {18'h0, exp_ts});
      $display("test random samples done");
      close_out;
   end
endmodule
